// File: logic/crc_engine_pkg.sv
// Constants, command codes, timing counts and carrier types of the memory-range checksum engine.

package crc_engine_pkg;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] opc_compute       = 8'h5b;
    localparam logic [7:0] opc_pause         = 8'h75;
    localparam logic [7:0] opc_continue      = 8'h7a;
    localparam logic [7:0] opc_read_any      = 8'h65;
    localparam logic [7:0] opc_ecc_read      = 8'h19;
    localparam logic [7:0] opc_ecc_clear     = 8'h1b;
    localparam logic [7:0] opc_read_ident    = 8'h9f;
    localparam logic [7:0] opc_read_serial   = 8'hc3;
    localparam logic [7:0] opc_reset_enable  = 8'h66;
    localparam logic [7:0] opc_reset         = 8'h99;

    // ----------------------------------------------------------------
    // Frame layout, address widths and checksum constants
    // ----------------------------------------------------------------
    localparam int          addr_w        = 24;
    localparam int          array_w       = 21;
    localparam int          frame_bits    = 56;
    localparam logic [6:0]  frame_len     = 7'h38;
    localparam logic [6:0]  opcode_len    = 7'h08;
    localparam logic [24:0] min_span      = 25'h0000003;
    localparam logic [31:0] crc_poly      = 32'h1edc6f41;
    localparam logic [31:0] result_reset  = 32'h00000000;
    localparam int          wip_bit       = 0;
    localparam int          abort_bit     = 3;
    localparam int          paused_bit    = 4;

    // ----------------------------------------------------------------
    // Timing: pause and continue processing times
    // ----------------------------------------------------------------
    localparam int          clk_period_ps    = 8000;
    localparam int          pause_time_ns    = 100;
    localparam int          continue_time_ns = 100;
    localparam int          pause_cycles_i   = (pause_time_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
    localparam int          cont_cycles_i    = (continue_time_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
    localparam logic [7:0]  pause_cycles     = 8'(pause_cycles_i);
    localparam logic [7:0]  continue_cycles  = 8'(cont_cycles_i);

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic [18:0] word_addr;
    } mem_req_t;

    typedef struct packed {
        logic abort;
        logic paused;
        logic work_in_progress_flag;
    } crc_status_t;

endpackage : crc_engine_pkg

// File: logic/memory_range_crc_engine.sv
// Checksum engine: serial command capture, range walker and CRC-32C datapath.
`timescale 1ns/1ps
`default_nettype none

module memory_range_crc_engine (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       sclk,
    input  wire logic                       cs_n,
    input  wire logic                       sdi,
    input  wire logic                       read_class_opcode,
    input  wire logic                       power_down,
    input  wire logic                       soft_reset,
    output crc_engine_pkg::mem_req_t        mem_req,
    input  wire logic [31:0]                mem_rdata,
    input  wire logic                       mem_rvalid,
    output logic [7:0]                      status_reg_one,
    output logic [7:0]                      status_reg_two,
    output logic [31:0]                     crc_result,
    output logic                            wel_clear,
    output logic                            cmd_refused
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // One byte through the non-reflected checksum, most significant bit first.
    function automatic logic [31:0] crc_byte(input logic [31:0] crc_in, input logic [7:0] data);
        logic [31:0] c;
        logic        fb;
        c = crc_in;
        for (int i = 7; i >= 0; i--) begin
            fb = c[31] ^ data[i];
            c  = {c[30:0], 1'b0} ^ (fb ? crc_engine_pkg::crc_poly : 32'h00000000);
        end
        return c;
    endfunction : crc_byte

    // Commands still allowed while a job is parked.
    function automatic logic permitted_paused(input logic [7:0] opc, input logic read_class);
        return read_class
            || opc == crc_engine_pkg::opc_read_any   || opc == crc_engine_pkg::opc_ecc_read
            || opc == crc_engine_pkg::opc_ecc_clear  || opc == crc_engine_pkg::opc_read_ident
            || opc == crc_engine_pkg::opc_read_serial
            || opc == crc_engine_pkg::opc_reset_enable || opc == crc_engine_pkg::opc_reset
            || opc == crc_engine_pkg::opc_continue;
    endfunction : permitted_paused

    // ----------------------------------------------------------------
    // Link side, clocked by the serial clock
    // ----------------------------------------------------------------
    // The serial clock stops between frames, so the start-of-frame marker is
    // preset by chip select itself; only that flag uses it as a preset.
    logic                 first_bit;
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            first_bit <= 1'b1;
        end else begin
            first_bit <= 1'b0;
        end
    end

    logic [55:0] link_shift;
    logic [6:0]  link_count;
    logic [7:0]  link_opc;
    logic [55:0] next_link_shift;
    logic [6:0]  next_link_count;
    logic [7:0]  next_link_opc;

    // Shift in one bit per rising edge, count saturating so overlong frames stay overlong.
    always_comb begin
        next_link_shift = {link_shift[54:0], sdi};
        next_link_opc   = link_opc;
        if (first_bit) begin
            next_link_count = 7'h01;
        end else if (link_count != 7'h7f) begin
            next_link_count = link_count + 7'h01;
        end else begin
            next_link_count = link_count;
        end
        if (next_link_count == crc_engine_pkg::opcode_len) begin
            next_link_opc = {link_shift[6:0], sdi};
        end
    end

    // Frame contents stay still after the last edge until the core reads them.
    always_ff @(posedge sclk) begin
        link_shift <= next_link_shift;
        link_count <= next_link_count;
        link_opc   <= next_link_opc;
    end

    // ----------------------------------------------------------------
    // Chip-select crossing into the core domain
    // ----------------------------------------------------------------
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= cs_n;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    // frame ends only on the rise
    logic frame_end;
    assign frame_end = cs_sync && !cs_prev;

    // Frame words are quasi-static here: the serial clock is idle while chip select is high.
    logic [7:0]  frm_opc;
    logic [23:0] frm_start;
    logic [23:0] frm_end;
    logic        frm_full;
    logic        frm_short;
    assign frm_opc   = link_opc;
    assign frm_start = link_shift[47:24];
    assign frm_end   = link_shift[23:0];
    assign frm_full  = link_count == crc_engine_pkg::frame_len;
    assign frm_short = link_count == crc_engine_pkg::opcode_len;

    // ----------------------------------------------------------------
    // Job state machine and datapath
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle,
        st_fetch,
        st_wait,
        st_feed,
        st_paused,
        st_resume
    } job_state_t;

    job_state_t       state;
    job_state_t       next_state;
    logic [20:0]      ptr;
    logic [20:0]      next_ptr;
    logic [20:0]      last;
    logic [20:0]      next_last;
    logic [31:0]      word;
    logic [31:0]      next_word;
    logic [31:0]      crc;
    logic [31:0]      next_crc;
    logic             abort;
    logic             next_abort;
    logic             paused;
    logic             next_paused;
    logic             pause_pend;
    logic             next_pause_pend;
    logic [7:0]       timer;
    logic [7:0]       next_timer;
    logic             next_wel_clear;
    logic             next_cmd_refused;
    logic             next_rd;
    logic             rd;
    logic [7:0]       lane;
    logic             range_bad;
    logic             job_active;

    // the end must reach at least start plus three
    assign range_bad  = {1'b0, frm_end} < ({1'b0, frm_start} + crc_engine_pkg::min_span);
    assign job_active = state != st_idle && state != st_paused;

    // the lane at the lowest address goes into the checksum first
    always_comb begin
        unique case (ptr[1:0])
            2'b00:   lane = word[7:0];
            2'b01:   lane = word[15:8];
            2'b10:   lane = word[23:16];
            2'b11:   lane = word[31:24];
        endcase
    end

    // Next job state, pointers, flags and checksum.
    always_comb begin
        next_state       = state;
        next_ptr         = ptr;
        next_last        = last;
        next_word        = word;
        next_crc         = crc;
        next_abort       = abort;
        next_paused      = paused;
        next_pause_pend  = pause_pend;
        next_timer       = (timer != 8'h00) ? timer - 8'h01 : 8'h00;
        next_wel_clear   = 1'b0;
        next_cmd_refused = 1'b0;
        next_rd          = 1'b0;

        unique case (state)
            st_idle: begin
                if (frame_end && frm_full && frm_opc == crc_engine_pkg::opc_compute) begin
                    // result starts from zero on every job
                    next_crc = crc_engine_pkg::result_reset;
                    if (range_bad) begin
                        next_abort = 1'b1;
                    end else begin
                        // a valid job clears the abort flag
                        next_abort = 1'b0;
                        // only main array addresses are walked
                        next_ptr   = frm_start[crc_engine_pkg::array_w-1:0];
                        next_last  = frm_end[crc_engine_pkg::array_w-1:0];
                        next_state = st_fetch;
                    end
                end
            end
            st_fetch: begin
                // a pending pause parks the job at a word boundary
                if (pause_pend && timer == 8'h00) begin
                    next_pause_pend = 1'b0;
                    next_paused     = 1'b1;
                    next_state      = st_paused;
                end else begin
                    next_rd    = 1'b1;
                    next_state = st_wait;
                end
            end
            st_wait: begin
                if (mem_rvalid) begin
                    next_word  = mem_rdata;
                    next_state = st_feed;
                end
            end
            st_feed: begin
                // one byte per cycle through CRC-32C
                next_crc = crc_byte(crc, lane);
                next_ptr = ptr + 21'h000001;
                // the end byte itself is included before stopping
                if (ptr == last) begin
                    // finishing first leaves the paused flag low
                    next_pause_pend = 1'b0;
                    // write latch is cleared at completion
                    next_wel_clear  = 1'b1;
                    next_state      = st_idle;
                end else if (ptr[1:0] == 2'b11) begin
                    next_state = st_fetch;
                end
            end
            st_paused: begin
                if (frame_end && frm_short && frm_opc == crc_engine_pkg::opc_continue) begin
                    // paused drops, busy rises until completion
                    next_paused = 1'b0;
                    next_timer  = crc_engine_pkg::continue_cycles;
                    next_state  = st_resume;
                end else if (frame_end) begin
                    next_cmd_refused = !permitted_paused(frm_opc, read_class_opcode);
                end
            end
            st_resume: begin
                // carry on from the saved pointer
                if (timer == 8'h00) begin
                    next_state = st_fetch;
                end
            end
            default: next_state = st_idle;
        endcase

        // pause is taken only while a job runs
        if (job_active && state != st_resume && !pause_pend && frame_end && frm_short
            && frm_opc == crc_engine_pkg::opc_pause) begin
            next_pause_pend = 1'b1;
            next_timer      = crc_engine_pkg::pause_cycles;
        end

        // power-down and soft reset lose the job and result
        if (power_down || soft_reset) begin
            next_state      = st_idle;
            next_crc        = crc_engine_pkg::result_reset;
            next_paused     = 1'b0;
            next_pause_pend = 1'b0;
            next_abort      = 1'b0;
        end
    end

    // Job registers; result is zero from reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state       <= st_idle;
            ptr         <= 21'h000000;
            last        <= 21'h000000;
            word        <= 32'h00000000;
            crc         <= crc_engine_pkg::result_reset;
            abort       <= 1'b0;
            paused      <= 1'b0;
            pause_pend  <= 1'b0;
            timer       <= 8'h00;
            wel_clear   <= 1'b0;
            cmd_refused <= 1'b0;
            rd          <= 1'b0;
        end else begin
            state       <= next_state;
            ptr         <= next_ptr;
            last        <= next_last;
            word        <= next_word;
            crc         <= next_crc;
            abort       <= next_abort;
            paused      <= next_paused;
            pause_pend  <= next_pause_pend;
            timer       <= next_timer;
            wel_clear   <= next_wel_clear;
            cmd_refused <= next_cmd_refused;
            rd          <= next_rd;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    crc_engine_pkg::crc_status_t status;

    // busy covers running, pause processing and continue processing
    // paused rises in the same cycle that busy falls
    always_comb begin
        status.work_in_progress_flag    = job_active;
        status.paused = paused;
        status.abort  = abort;
    end

    // result word is the checksum register itself
    assign crc_result = crc;
    assign mem_req.rd        = rd;
    assign mem_req.word_addr = ptr[20:2];

    // Only this block's bits are placed; the rest belong to other status logic.
    always_comb begin
        status_reg_one = 8'h00;
        status_reg_two = 8'h00;
        status_reg_one[crc_engine_pkg::wip_bit]    = status.work_in_progress_flag;
        status_reg_two[crc_engine_pkg::abort_bit]  = status.abort;
        status_reg_two[crc_engine_pkg::paused_bit] = status.paused;
    end

endmodule : memory_range_crc_engine

`default_nettype wire

// File: tb/memory_range_crc_engine_assertions.sv
// Port checks for the memory-range checksum engine.
`timescale 1ns/1ps
`default_nettype none

module memory_range_crc_engine_assertions (
    input wire logic                     core_clk,
    input wire logic                     rst,
    input wire logic                     power_down,
    input wire logic                     soft_reset,
    input wire crc_engine_pkg::mem_req_t mem_req,
    input wire logic [7:0]               status_reg_one,
    input wire logic [7:0]               status_reg_two,
    input wire logic [31:0]              crc_result,
    input wire logic                     wel_clear,
    input wire logic                     cmd_refused
);
    // Short names for the three status flags.
    wire busy   = status_reg_one[0];
    wire abort  = status_reg_two[3];
    wire paused = status_reg_two[4];

    // ------------------------------------------------------------
    // Status, result and fetch relations
    // ------------------------------------------------------------
    property p_one_flag;
        @(posedge core_clk) disable iff (rst) !(busy && paused);
    endproperty
    a_one_flag: assert property (p_one_flag) else $error("busy and paused together");
    property p_wel_end;
        @(posedge core_clk) disable iff (rst) wel_clear |-> !busy && $past(busy);
    endproperty
    a_wel_end: assert property (p_wel_end) else $error("latch clear off job end");
    property p_abort;
        @(posedge core_clk) disable iff (rst) $rose(abort) |-> !busy && ~|crc_result;
    endproperty
    a_abort: assert property (p_abort) else $error("abort left engine busy");
    property p_clear_start;
        @(posedge core_clk) disable iff (rst) $rose(busy) && !$past(paused) |-> ~|crc_result;
    endproperty
    a_clear_start: assert property (p_clear_start) else $error("result kept at start");
    property p_fetch_start;
        @(posedge core_clk) disable iff (rst) $rose(busy) && !$past(paused) |-> ##[0:2] mem_req.rd;
    endproperty
    a_fetch_start: assert property (p_fetch_start) else $error("job fetched nothing");
    // A power-down or reset may also drop the paused flag, so those are excluded.
    property p_cont_busy;
        @(posedge core_clk) disable iff (rst)
            $fell(paused) && !$past(power_down) && !$past(soft_reset) && !$past(rst) |-> busy;
    endproperty
    a_cont_busy: assert property (p_cont_busy) else $error("continue left busy low");
    property p_cont_fetch;
        @(posedge core_clk) disable iff (rst) $fell(paused) && busy |-> ##[1:20] mem_req.rd;
    endproperty
    a_cont_fetch: assert property (p_cont_fetch) else $error("continue fetched nothing");
    property p_refuse;
        @(posedge core_clk) disable iff (rst) cmd_refused |-> paused;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal outside pause");
endmodule : memory_range_crc_engine_assertions

bind memory_range_crc_engine memory_range_crc_engine_assertions memory_range_crc_engine_assertions_i (
    .core_clk(core_clk), .rst(rst), .power_down(power_down), .soft_reset(soft_reset),
    .mem_req(mem_req), .status_reg_one(status_reg_one), .status_reg_two(status_reg_two),
    .crc_result(crc_result), .wel_clear(wel_clear), .cmd_refused(cmd_refused)
);
`default_nettype wire

// File: tb/crc_host_model.sv
// Host serial controller model that frames commands onto the link.
`timescale 1ns/1ps
`default_nettype none

module crc_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    // The link clock stands still low between frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        sdi  = 1'b0;
        // A first rise presets the start-of-frame marker before any real frame.
        #1 cs_n = 1'b1;
    end

    task automatic send_frame(input logic [55:0] bits, input int n);
        #3.7 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = bits[55-i];
            #7.5 sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
        cs_n = 1'b1;
        // Released data shows the inverse so a stale bit never reads as valid.
        sdi = ~sdi;
        #100;
    endtask : send_frame
endmodule : crc_host_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench of the memory-range checksum engine.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        core_clk = 1'b0, rst = 1'b1, read_class_opcode = 1'b0;
    logic        power_down = 1'b0, soft_reset = 1'b0, mem_rvalid = 1'b0;
    logic [31:0] mem_rdata = 32'h00000000, crc_result;
    logic [7:0]  status_reg_one, status_reg_two;
    logic        wel_clear, cmd_refused;
    wire         sclk, cs_n, sdi;
    int          mem_lat = 2, mem_wait = 0, wel_seen = 0, refused_seen = 0;
    int          mismatches = 0, comparisons = 0;
    crc_engine_pkg::mem_req_t mem_req;

    memory_range_crc_engine memory_range_crc_engine_i (
        .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .read_class_opcode(read_class_opcode), .power_down(power_down),
        .soft_reset(soft_reset), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .status_reg_one(status_reg_one),
        .status_reg_two(status_reg_two), .crc_result(crc_result),
        .wel_clear(wel_clear), .cmd_refused(cmd_refused));
    crc_host_model crc_host_model_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    always #4 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Memory model and reference checksum
    // ------------------------------------------------------------
    function automatic logic [7:0] mem_byte(input logic [20:0] a);
        return a[7:0] ^ {a[10:8], a[15:11]} ^ 8'h5a;
    endfunction : mem_byte

    function automatic logic [31:0] word_of(input logic [18:0] w);
        return {mem_byte({w, 2'd3}), mem_byte({w, 2'd2}), mem_byte({w, 2'd1}), mem_byte({w, 2'd0})};
    endfunction : word_of

    function automatic logic [31:0] ref_crc(input int sa, input int ea);
        logic [31:0] c;
        logic [7:0]  b;
        c = 32'h00000000;
        for (int a = sa; a <= ea; a++) begin
            b = mem_byte(21'(a));
            for (int k = 7; k >= 0; k--) begin
                c = {c[30:0], 1'b0} ^ ((c[31] ^ b[k]) ? crc_engine_pkg::crc_poly : 32'h0);
            end
        end
        return c;
    endfunction : ref_crc

    // Fetches answer after mem_lat cycles; idle data toggles so stale words never match.
    always @(negedge core_clk) begin
        mem_rvalid   <= (mem_wait == 1);
        mem_rdata    <= (mem_wait == 1) ? word_of(mem_req.word_addr) : ~mem_rdata;
        mem_wait     <= mem_req.rd ? mem_lat : (mem_wait > 0 ? mem_wait - 1 : 0);
        wel_seen     <= wel_seen + int'(wel_clear === 1'b1);
        refused_seen <= refused_seen + int'(cmd_refused === 1'b1);
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_flags(input logic [7:0] one, input logic [7:0] two);
        comparisons++;
        if ({status_reg_one, status_reg_two} !== {one, two}) begin
            mismatches++;
            $display("mismatch at %0t: status %h %h", $time, status_reg_one, status_reg_two);
        end
    endtask : check_flags

    // The read-class hint settles off the sampling edge and holds through the frame.
    task automatic frame(input logic [55:0] bits, input int n, input logic cls);
        @(negedge core_clk);
        read_class_opcode = cls;
        crc_host_model_i.send_frame(bits, n);
    endtask : frame

    task automatic compute(input logic [20:0] sa, input logic [20:0] ea);
        frame({crc_engine_pkg::opc_compute, 3'h0, sa, 3'h0, ea}, 56, 1'b0);
    endtask : compute

    task automatic wait_for(input logic busy, input logic paused);
        int n;
        for (n = 0; n < 20000; n++) begin
            if ({status_reg_one[0], status_reg_two[4]} === {busy, paused}) break;
            @(negedge core_clk);
        end
        if (n == 20000) begin
            mismatches++;
            $display("mismatch at %0t: status wait expired", $time);
        end
    endtask : wait_for

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [55:0] ok;
        ok = {crc_engine_pkg::opc_read_any, crc_engine_pkg::opc_ecc_read,
              crc_engine_pkg::opc_ecc_clear, crc_engine_pkg::opc_read_ident,
              crc_engine_pkg::opc_read_serial, crc_engine_pkg::opc_reset_enable,
              crc_engine_pkg::opc_reset};
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        check_flags(8'h00, 8'h00);
        check_word(crc_result, 32'h00000000);
        frame({crc_engine_pkg::opc_continue, 48'h0}, 8, 1'b0);
        check_flags(8'h00, 8'h00);
        frame({crc_engine_pkg::opc_pause, 48'h0}, 8, 1'b0);
        check_flags(8'h00, 8'h00);
        $display("test idle done");
        mem_lat = 6;
        compute(21'h000011, 21'h0002ff);
        check_flags(8'h01, 8'h00);
        wait_for(1'b0, 1'b0);
        check_word(crc_result, ref_crc(32'h11, 32'h2ff));
        // The latch-clear pulse is only counted after the falling edge that sees it.
        @(negedge core_clk);
        check_word(32'(wel_seen), 32'h00000001);
        $display("test compute done");
        mem_lat = 1;
        compute(21'h000101, 21'h000103);
        check_flags(8'h00, 8'h08);
        compute(21'h000101, 21'h000104);
        wait_for(1'b0, 1'b0);
        check_flags(8'h00, 8'h00);
        check_word(crc_result, ref_crc(32'h101, 32'h104));
        $display("test abort done");
        mem_lat = 3;
        compute(21'h000000, 21'h0005ff);
        for (int k = 0; k < 3; k++) begin
            frame({crc_engine_pkg::opc_pause, 48'h0}, 8, 1'b0);
            wait_for(1'b0, 1'b1);
            check_flags(8'h00, 8'h10);
            if (k == 0) begin
                for (int i = 0; i < 7; i++) frame({ok[55-8*i -: 8], 48'h0}, 8, 1'b0);
                frame({8'h03, 48'h0}, 8, 1'b1);
                compute(21'h000000, 21'h000010);
                check_word(32'(refused_seen), 32'h00000001);
            end
            frame({crc_engine_pkg::opc_continue, 48'h0}, 8, 1'b0);
            check_flags(8'h01, 8'h00);
        end
        wait_for(1'b0, 1'b0);
        check_word(crc_result, ref_crc(32'h0, 32'h5ff));
        $display("test pause done");
        // A power-down and a soft reset each cut a running job short.
        for (int k = 0; k < 2; k++) begin
            compute(21'h000000, 21'h0003ff);
            @(negedge core_clk);
            power_down = (k == 0);
            soft_reset = (k == 1);
            @(negedge core_clk);
            power_down = 1'b0;
            soft_reset = 1'b0;
            repeat (2) @(negedge core_clk);
            check_flags(8'h00, 8'h00);
            check_word(crc_result, 32'h00000000);
        end
        $display("test reset done");
        summarize();
    end

    // The tests need just over 55 us; this limit of 400 us cuts a hang short.
    initial begin
        #400000;
        mismatches++;
        $display("mismatch at %0t: run did not finish", $time);
        summarize();
    end
endmodule : tb
`default_nettype wire
